/* File: hw/rmc_cfg.svh */
/*
 Offsets, field positions, reset values and timing of the radio command block.
 Assumes it is included by bare name wherever these macros are used.
*/
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH
// APB byte offsets
`define RMC_OFS_CMD     8'h00
`define RMC_OFS_ARG0    8'h04
`define RMC_OFS_ARG1    8'h08
`define RMC_OFS_REPLY   8'h0C
`define RMC_OFS_RES0    8'h10
`define RMC_OFS_RES1    8'h14
`define RMC_OFS_STAT    8'h18
// Field positions
`define RMC_CMD_HAS_ARG 8
// Timing
`define RMC_CLK_HZ      50000000
`define RMC_SCAN_UNIT_S 2
// Mode codes and reset values
`define RMC_MODE_MASTER 4'h1
`define RMC_MODE_MESH   4'h5
`define RMC_MODE_MAX    4'h8
`define RMC_RST_MODE    4'h5
`define RMC_RST_NETID   16'h0000
`define RMC_RST_SADDR   16'h0000
`define RMC_RST_FRIEND  48'h000000000000
`define RMC_BCAST_ADDR  16'hFFFF
`define RMC_FRAME_LEAD  8'h00
`define RMC_LIST_DEPTH  4'h8
`endif

/* File: hw/rmc_pkg.sv */
/*
 Types of the radio command block: commands, states, carriers.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rmc_pkg;
	// Command codes written to the command register
	typedef enum logic [7:0] {
		OP_NONE = 8'h00, OP_SLEEP = 8'h01, OP_DEFAULT = 8'h02, OP_SEARCH = 8'h03,
		OP_ABORT = 8'h04, OP_CONN_IDX = 8'h05, OP_CONN_ADDR = 8'h06, OP_BIND = 8'h07,
		OP_UNBIND = 8'h08, OP_AUTOBIND = 8'h09, OP_NET_SEND = 8'h0A, OP_KEYBIND = 8'h0B,
		OP_NETID = 8'h0C, OP_SADDR = 8'h0D, OP_NODETYPE = 8'h0E, OP_FRIEND_ADD = 8'h0F,
		OP_FRIEND_CLR = 8'h10, OP_MODE = 8'h11
	} rmc_op_type;
	// Reply codes
	typedef enum logic [1:0] {
		REP_NONE = 2'h0, REP_OK = 2'h1, REP_ERR = 2'h2
	} rmc_rep_type;
	// Power states
	typedef enum logic [1:0] {
		PW_AWAKE = 2'h0, PW_LIGHT = 2'h1, PW_DEEP = 2'h2
	} rmc_pw_type;
	// Key event sequencer, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01, ST_TXWAIT = 2'b10
	} rmc_st_type;
	typedef struct packed {
		logic [47:0] mac;
		logic [7:0]  rssi;
	} rmc_peer_type;
	typedef struct packed {
		logic [2:0]   idx;
		rmc_peer_type peer;
	} rmc_line_type;
	typedef struct packed {
		logic [15:0] target;
		logic        bcast;
		logic [31:0] data;
	} rmc_send_type;
	typedef struct packed {
		logic [15:0] addr;
		logic [2:0]  out;
		logic        echo;
	} rmc_key_type;
endpackage : rmc_pkg

/* File: hw/rmc_top.sv */
/*
 Command interpreter of the radio module, as APB registers.
 Assumes radio-side signals share CLK; KEY_IN comes from pins.
*/
`timescale 1ns/1ps
`include "rmc_cfg.svh"
module rmc_top #(
	parameter int SCAN_UNIT_CYCLES = `RMC_SCAN_UNIT_S * `RMC_CLK_HZ,
	parameter int NUM_KEYS         = 5
)(
	input  wire logic                  CLK,
	input  wire logic                  RST_N,
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [7:0]            PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic      [31:0]           PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	input  wire logic                  PEER_VALID,
	input  wire rmc_pkg::rmc_peer_type PEER,
	output logic                       SCAN_ACTIVE,
	output logic                       SCAN_LINE_VALID,
	output rmc_pkg::rmc_line_type      SCAN_LINE,
	output logic                       CONNECT_REQ,
	output logic      [47:0]           CONNECT_MAC,
	output logic      [47:0]           BOUND_MAC,
	output logic                       LIGHT_SLEEP,
	output logic                       DEEP_SLEEP,
	output logic                       ADVERTISE_EN,
	output logic                       NET_SEND_VALID,
	output rmc_pkg::rmc_send_type      NET_SEND,
	input  wire logic [4:0]            KEY_IN,
	output logic                       KEY_EVENT_VALID,
	output rmc_pkg::rmc_key_type       KEY_EVENT,
	input  wire logic                  TX_DONE,
	input  wire logic                  CENTRAL_ASSIGN_VALID,
	input  wire logic [15:0]           CENTRAL_ASSIGN_ADDR,
	output logic      [15:0]           NET_ID,
	output logic      [15:0]           SHORT_ADDR,
	output logic                       RELAY_EN,
	output logic      [47:0]           FRIEND_MAC
);
	// Search length in units of the scan step; 15 marks a bad argument
	function automatic logic [3:0] dur_units(input logic [2:0] a);
		case (a)
		3'h0: dur_units = 4'h1;
		3'h1: dur_units = 4'h2;
		3'h2: dur_units = 4'h3;
		3'h3: dur_units = 4'h4;
		3'h4: dur_units = 4'h8;
		default: dur_units = 4'hF;
		endcase
	endfunction : dur_units

	// Lowest pressed key, numbered from 1; 0 when none
	function automatic logic [2:0] first_key(input logic [4:0] k);
		first_key = 3'h0;
		for (int i = 4; i >= 0; i--)
			if (k[i])
				first_key = 3'(i + 1);
	endfunction : first_key

	logic [31:0]                a0_q;
	logic [23:0]                a1_q;
	logic [31:0]                prdata_q;
	rmc_pkg::rmc_rep_type       rep_code_q;
	logic [7:0]                 rep_seq_q;
	logic [47:0]                rep_val_q;
	logic [3:0]                 mode_q;
	logic [15:0]                netid_q;
	logic [15:0]                saddr_q;
	logic                       ntype_q;
	logic [47:0]                friend_q;
	logic [47:0]                bound_q;
	logic [2:0]                 conn_idx_q;
	rmc_pkg::rmc_pw_type        pw_q;
	rmc_pkg::rmc_key_type       kb_q [NUM_KEYS];
	logic [NUM_KEYS-1:0]        kv_q;
	logic                       scan_q;
	logic                       autob_q;
	logic [31:0]                cyc_q;
	logic [3:0]                 units_q;
	rmc_pkg::rmc_peer_type      list_q [8];
	logic [3:0]                 count_q;
	logic                       best_v_q;
	rmc_pkg::rmc_peer_type      best_q;
	logic                       conn_req_q;
	logic [47:0]                conn_mac_q;
	logic                       line_v_q;
	rmc_pkg::rmc_line_type      line_q;
	logic                       send_v_q;
	rmc_pkg::rmc_send_type      send_q;
	logic [4:0]                 key_s1_q;
	logic [4:0]                 key_s2_q;
	logic [4:0]                 key_s3_q;
	rmc_pkg::rmc_st_type        st_q;
	logic                       kev_v_q;
	rmc_pkg::rmc_key_type       kev_q;
	logic                       ok;
	logic                       isq;
	logic [47:0]                val;

	// APB decode
	wire        apb_wr   = PSEL & PENABLE & PWRITE;
	wire        cmd_go   = apb_wr & (PADDR == `RMC_OFS_CMD);
	wire rmc_pkg::rmc_op_type op = rmc_pkg::rmc_op_type'(PWDATA[7:0]);
	wire        has      = PWDATA[`RMC_CMD_HAS_ARG];
	wire        hit      = (PADDR <= `RMC_OFS_STAT) & (PADDR[1:0] == 2'h0);
	wire [47:0] arg_mac  = {a1_q[15:0], a0_q};
	wire [2:0]  kn       = a1_q[2:0];
	wire [2:0]  ki       = kn - 3'h1;
	wire        key_ok   = (kn != 3'h0) & (32'(kn) <= NUM_KEYS);
	wire        master   = mode_q == `RMC_MODE_MASTER;
	wire        mesh     = mode_q == `RMC_MODE_MESH;
	wire        acc      = cmd_go & ok;
	wire        set      = acc & has;
	wire [3:0]  dur      = dur_units((op == rmc_pkg::OP_SEARCH && has) ? a0_q[2:0] : 3'h0);
	wire        scan_go  = acc & ((op == rmc_pkg::OP_SEARCH) | (op == rmc_pkg::OP_AUTOBIND));
	wire        abort_go = acc & (op == rmc_pkg::OP_ABORT);
	wire        tick     = cyc_q == 32'(SCAN_UNIT_CYCLES - 1);
	wire        scan_end = scan_q & tick & (units_q == 4'h1);
	wire        room     = count_q < `RMC_LIST_DEPTH;
	wire        stronger = !best_v_q | ($signed(PEER.rssi) > $signed(best_q.rssi));
	wire [4:0]  key_rise = key_s2_q & ~key_s3_q;
	wire [2:0]  kfirst   = first_key(key_rise);
	wire        kfire    = mesh & (kfirst != 3'h0) & kv_q[kfirst - 3'h1];
	wire        term     = mesh & ntype_q;

	// Read mux; reserved bits read as zero
	wire [31:0] rd_word =
		(PADDR == `RMC_OFS_ARG0)  ? a0_q :
		(PADDR == `RMC_OFS_ARG1)  ? {8'h00, a1_q} :
		(PADDR == `RMC_OFS_REPLY) ? {16'h0000, rep_seq_q, 6'h00, rep_code_q} :
		(PADDR == `RMC_OFS_RES0)  ? rep_val_q[31:0] :
		(PADDR == `RMC_OFS_RES1)  ? {16'h0000, rep_val_q[47:32]} :
		(PADDR == `RMC_OFS_STAT)  ? {20'h00000, count_q, 1'b0, st_q == rmc_pkg::ST_TXWAIT,
			autob_q, scan_q, 2'h0, pw_q} :
		32'h00000000;

	// Zero-wait slave; read data is caught in the setup cycle
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~hit;
	assign PRDATA  = prdata_q;

	// Legality of the command and the value a query reports
	always_comb
	begin
		ok  = 1'b1;
		isq = !has;
		val = 48'h0;
		case (op)
		rmc_pkg::OP_SLEEP: ok = mesh ? (has && a0_q == 32'h2) : (!has || a0_q == 32'h1);
		rmc_pkg::OP_SEARCH: ok = master && !scan_q && (!has || a0_q <= 32'h4);
		rmc_pkg::OP_AUTOBIND: ok = master && !scan_q;
		rmc_pkg::OP_CONN_IDX: ok = !has || (a0_q < 32'h8 && a0_q < 32'(count_q));
		rmc_pkg::OP_BIND: ok = master;
		rmc_pkg::OP_UNBIND: ok = master;
		// frame lead byte must be zero
		rmc_pkg::OP_NET_SEND: ok = mesh && has && a1_q[23:16] == `RMC_FRAME_LEAD;
		// key and output numbers 1 to 5
		rmc_pkg::OP_KEYBIND: ok = key_ok && (!has || (a0_q[18:16] != 3'h0 && a0_q[18:16] <= 3'h5));
		// zero is not a node identity
		rmc_pkg::OP_SADDR: ok = !has || a0_q[15:0] != 16'h0000;
		rmc_pkg::OP_NODETYPE: ok = !has || a0_q <= 32'h1;
		rmc_pkg::OP_MODE: ok = !has || a0_q <= 32'(`RMC_MODE_MAX);
		rmc_pkg::OP_DEFAULT, rmc_pkg::OP_ABORT, rmc_pkg::OP_CONN_ADDR,
		rmc_pkg::OP_FRIEND_ADD, rmc_pkg::OP_FRIEND_CLR, rmc_pkg::OP_NETID: ok = 1'b1;
		default: ok = 1'b0;
		endcase
		case (op)
		rmc_pkg::OP_CONN_IDX: val = {45'h0, conn_idx_q};
		rmc_pkg::OP_BIND: val = bound_q;
		rmc_pkg::OP_KEYBIND: val = {27'h0, kv_q[ki], kb_q[ki]};
		rmc_pkg::OP_NETID: val = {32'h0, netid_q};
		rmc_pkg::OP_SADDR: val = {32'h0, saddr_q};
		rmc_pkg::OP_NODETYPE: val = {47'h0, ntype_q};
		rmc_pkg::OP_FRIEND_ADD: val = friend_q;
		rmc_pkg::OP_MODE: val = {44'h0, mode_q};
		default: isq = 1'b0;
		endcase
	end

	// Bus registers and reply
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			a0_q       <= 32'h00000000;
			a1_q       <= 24'h000000;
			prdata_q   <= 32'h00000000;
			rep_code_q <= rmc_pkg::REP_NONE;
			rep_seq_q  <= 8'h00;
			rep_val_q  <= 48'h0;
		end
		else
		begin
			if (PSEL & ~PENABLE)
				prdata_q <= rd_word;
			if (apb_wr & (PADDR == `RMC_OFS_ARG0))
				a0_q <= PWDATA;
			if (apb_wr & (PADDR == `RMC_OFS_ARG1))
				a1_q <= PWDATA[23:0];
			if (cmd_go)
			begin
				rep_code_q <= ok ? rmc_pkg::REP_OK : rmc_pkg::REP_ERR;
				rep_seq_q  <= rep_seq_q + 8'h01;
				rep_val_q  <= (ok & isq) ? val : 48'h0;
			end
		end
	end

	// Settings; a command outranks a central assignment in the same cycle
	always_ff @(posedge CLK)
	begin
		if (!RST_N || (acc && op == rmc_pkg::OP_DEFAULT))
		begin
			mode_q     <= `RMC_RST_MODE;
			netid_q    <= `RMC_RST_NETID;
			saddr_q    <= `RMC_RST_SADDR;
			ntype_q    <= 1'b0;
			friend_q   <= `RMC_RST_FRIEND;
			bound_q    <= 48'h0;
			conn_idx_q <= 3'h0;
			pw_q       <= rmc_pkg::PW_AWAKE;
			kv_q       <= '0;
		end
		else if (acc)
		begin
			// Any accepted command wakes the module first
			pw_q <= rmc_pkg::PW_AWAKE;
			case (op)
			rmc_pkg::OP_SLEEP: pw_q <= (has && a0_q == 32'h2) ? rmc_pkg::PW_DEEP : rmc_pkg::PW_LIGHT;
			rmc_pkg::OP_CONN_IDX: if (has) conn_idx_q <= a0_q[2:0];
			rmc_pkg::OP_BIND: if (has) bound_q <= arg_mac;
			rmc_pkg::OP_UNBIND: bound_q <= 48'h0;
			rmc_pkg::OP_KEYBIND:
				if (has)
				begin
					kb_q[ki] <= {a0_q[15:0], a0_q[18:16], a0_q[20]};
					kv_q[ki] <= 1'b1;
				end
			rmc_pkg::OP_NETID: if (has) netid_q <= a0_q[15:0];
			rmc_pkg::OP_SADDR: if (has) saddr_q <= a0_q[15:0];
			rmc_pkg::OP_NODETYPE: if (has) ntype_q <= a0_q[0];
			rmc_pkg::OP_FRIEND_ADD: if (has) friend_q <= arg_mac;
			rmc_pkg::OP_FRIEND_CLR: friend_q <= 48'h0;
			rmc_pkg::OP_MODE: if (has) mode_q <= a0_q[3:0];
			default: ;
			endcase
		end
		else if (scan_end & autob_q & best_v_q)
			bound_q <= best_q.mac;
		else if (CENTRAL_ASSIGN_VALID & ~cmd_go & mesh & (saddr_q == 16'h0000)
			& (CENTRAL_ASSIGN_ADDR != 16'h0000))
			saddr_q <= CENTRAL_ASSIGN_ADDR;
	end

	// search timer, ended by time or abort
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			scan_q  <= 1'b0;
			autob_q <= 1'b0;
			cyc_q   <= 32'h0;
			units_q <= 4'h0;
		end
		else if (scan_go)
		begin
			scan_q  <= 1'b1;
			autob_q <= op == rmc_pkg::OP_AUTOBIND;
			cyc_q   <= 32'h0;
			units_q <= dur;
		end
		else if (abort_go | scan_end)
		begin
			scan_q  <= 1'b0;
			autob_q <= 1'b0;
		end
		else if (scan_q)
		begin
			cyc_q   <= tick ? 32'h0 : cyc_q + 32'h1;
			units_q <= tick ? units_q - 4'h1 : units_q;
		end
	end

	// result list, one line per peer found until eight lines are held
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			count_q  <= 4'h0;
			best_v_q <= 1'b0;
			best_q   <= '0;
			line_v_q <= 1'b0;
			line_q   <= '0;
		end
		else
		begin
			line_v_q <= scan_q & PEER_VALID & room & ~scan_go;
			if (scan_go)
			begin
				count_q  <= 4'h0;
				best_v_q <= 1'b0;
			end
			else if (scan_q & PEER_VALID & room)
			begin
				list_q[count_q[2:0]] <= PEER;
				line_q               <= {count_q[2:0], PEER};
				count_q              <= count_q + 4'h1;
				if (stronger)
				begin
					best_q   <= PEER;
					best_v_q <= 1'b1;
				end
			end
		end
	end

	// Connect requests and mesh send
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			conn_req_q <= 1'b0;
			conn_mac_q <= 48'h0;
			send_v_q   <= 1'b0;
			send_q     <= '0;
		end
		else
		begin
			conn_req_q <= 1'b0;
			send_v_q   <= 1'b0;
			if (set & (op == rmc_pkg::OP_CONN_IDX))
			begin
				conn_req_q <= 1'b1;
				conn_mac_q <= list_q[a0_q[2:0]].mac;
			end
			else if (acc & (op == rmc_pkg::OP_CONN_ADDR))
			begin
				conn_req_q <= 1'b1;
				conn_mac_q <= arg_mac;
			end
			else if (scan_end & autob_q & best_v_q)
			begin
				conn_req_q <= 1'b1;
				conn_mac_q <= best_q.mac;
			end
			if (acc & (op == rmc_pkg::OP_NET_SEND))
			begin
				send_v_q <= 1'b1;
				send_q   <= {a1_q[15:0], a1_q[15:0] == `RMC_BCAST_ADDR, a0_q};
			end
		end
	end

	// Key pins pass two flops; the third only detects the edge
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			key_s1_q <= 5'h00;
			key_s2_q <= 5'h00;
			key_s3_q <= 5'h00;
		end
		else
		begin
			key_s1_q <= KEY_IN;
			key_s2_q <= key_s1_q;
			key_s3_q <= key_s2_q;
		end
	end

	// key event; a terminal not in PW_DEEP stays awake until sent
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			st_q    <= rmc_pkg::ST_IDLE;
			kev_v_q <= 1'b0;
			kev_q   <= '0;
		end
		else
		begin
			kev_v_q <= 1'b0;
			case (st_q)
			rmc_pkg::ST_IDLE:
				if (kfire)
				begin
					kev_v_q <= 1'b1;
					kev_q   <= kb_q[kfirst - 3'h1];
					st_q    <= term ? rmc_pkg::ST_TXWAIT : rmc_pkg::ST_IDLE;
				end
			rmc_pkg::ST_TXWAIT: if (TX_DONE) st_q <= rmc_pkg::ST_IDLE;
			default: st_q <= rmc_pkg::ST_IDLE;
			endcase
		end
	end

	// Outputs; a terminal node sleeps whenever it is not sending
	assign SCAN_ACTIVE     = scan_q;
	assign SCAN_LINE_VALID = line_v_q;
	assign SCAN_LINE       = line_q;
	assign CONNECT_REQ     = conn_req_q;
	assign CONNECT_MAC     = conn_mac_q;
	assign BOUND_MAC       = bound_q;
	assign LIGHT_SLEEP     = pw_q == rmc_pkg::PW_LIGHT;
	assign DEEP_SLEEP      = (pw_q == rmc_pkg::PW_DEEP) | (term & (st_q == rmc_pkg::ST_IDLE));
	assign ADVERTISE_EN    = ~DEEP_SLEEP;
	assign NET_SEND_VALID  = send_v_q;
	assign NET_SEND        = send_q;
	assign KEY_EVENT_VALID = kev_v_q;
	assign KEY_EVENT       = kev_q;
	assign NET_ID          = netid_q;
	assign SHORT_ADDR      = saddr_q;
	assign RELAY_EN        = mesh & ~ntype_q;
	assign FRIEND_MAC      = friend_q;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	AST_SLEEP_LIGHT: assert property (acc && op == rmc_pkg::OP_SLEEP && !(has && a0_q == 32'h2) |=> LIGHT_SLEEP && ADVERTISE_EN) else $error("light sleep not entered");
	AST_SLEEP_DEEP: assert property (acc && op == rmc_pkg::OP_SLEEP && has && a0_q == 32'h2 |=> DEEP_SLEEP && !ADVERTISE_EN) else $error("deep sleep not entered");
	AST_SLEEP_MESH: assert property (cmd_go && op == rmc_pkg::OP_SLEEP && mesh && !(has && a0_q == 32'h2) |=> rep_code_q == rmc_pkg::REP_ERR && $stable(pw_q)) else $error("mesh took light sleep");
	AST_RESTORE: assert property (cmd_go && op == rmc_pkg::OP_DEFAULT |=> mode_q == `RMC_RST_MODE && friend_q == 48'h0 && rep_code_q == rmc_pkg::REP_OK) else $error("restore incomplete");
	AST_SCAN_END: assert property ($fell(scan_q) |-> $past(abort_go) || $past(scan_end)) else $error("search ended without cause");
	AST_LINE: assert property (SCAN_LINE_VALID |-> $past(scan_q && PEER_VALID) && $past(count_q) < `RMC_LIST_DEPTH) else $error("stray result line");
	AST_ABORT: assert property (cmd_go && op == rmc_pkg::OP_ABORT && scan_q |=> !SCAN_ACTIVE && rep_code_q == rmc_pkg::REP_OK) else $error("abort ignored");
	AST_CONN_RANGE: assert property (cmd_go && op == rmc_pkg::OP_CONN_IDX && has && a0_q >= 32'h8 |=> !CONNECT_REQ && rep_code_q == rmc_pkg::REP_ERR) else $error("bad index taken");
	AST_CONN_ADDR: assert property (cmd_go && op == rmc_pkg::OP_CONN_ADDR |=> CONNECT_REQ && CONNECT_MAC == $past(arg_mac)) else $error("direct connect lost");
	AST_UNBIND: assert property (acc && op == rmc_pkg::OP_UNBIND |=> BOUND_MAC == 48'h0) else $error("unbind left address");
	AST_BCAST: assert property (NET_SEND_VALID |-> $past(a1_q[23:16]) == `RMC_FRAME_LEAD && NET_SEND.data == $past(a0_q) && NET_SEND.bcast == ($past(a1_q[15:0]) == `RMC_BCAST_ADDR)) else $error("send frame wrong");
	AST_SADDR_ZERO: assert property (cmd_go && op == rmc_pkg::OP_SADDR && has && a0_q[15:0] == 16'h0 |=> $stable(SHORT_ADDR)) else $error("zero short address taken");
	AST_TERM_SLEEP: assert property (term && st_q == rmc_pkg::ST_TXWAIT && TX_DONE && !cmd_go |=> DEEP_SLEEP && !ADVERTISE_EN) else $error("terminal awake after send");
	AST_QUERY: assert property (cmd_go && op == rmc_pkg::OP_NETID && !has |=> $stable(NET_ID) && rep_val_q[15:0] == NET_ID) else $error("query changed value");
endmodule : rmc_top

/* File: tb/rmc_radio_model.sv */
/*
 Radio-side model for the command block: offers peers while a search runs.
 Assumes it shares CLK with the block and watches SCAN_ACTIVE.
*/
`timescale 1ns/1ps
module rmc_radio_model (
	input  wire logic             CLK,
	input  wire logic             SCAN_ACTIVE,
	input  wire logic             KEY_EVENT_VALID,
	output logic                  PEER_VALID,
	output rmc_pkg::rmc_peer_type PEER,
	output logic                  TX_DONE
);
	int  t = 0;
	wire hit = SCAN_ACTIVE && t >= 4 && t < 7;
	// one peer each cycle
	// Three peers after start, macs 4..6, mac 5 strongest at -40
	always @(posedge CLK)
	begin
		t <= SCAN_ACTIVE ? t + 1 : 0;
		PEER_VALID <= hit;
		// air send of a key event ends one cycle later
		TX_DONE <= KEY_EVENT_VALID;
		if (hit)
			PEER <= {44'h0, 4'(t), (t == 5) ? 8'hD8 : 8'hB0};
		else
			PEER <= ~PEER; // Released bus toggles so stale data never matches
	end
endmodule : rmc_radio_model

/* File: tb/tb_top.sv */
/*
 Testbench of the radio command block: APB tasks and command sequences.
 Assumes rmc_pkg, rmc_top and the radio model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
	logic                  clk = 0;
	logic                  rst_n = 0;
	logic                  psel = 0;
	logic                  penable = 0;
	logic                  pwrite = 0;
	logic [7:0]            paddr = 8'h00;
	logic [31:0]           pwdata = 32'h0;
	logic [31:0]           prdata, rd, res;
	logic                  pready, pslverr, err, peer_v, tx_done, line_v;
	logic                  scan_act, light, deep, adv, relay;
	logic                  conn_req, send_v, kev_v;
	logic                  cav = 0;
	logic [4:0]            key = 5'h00;
	logic [15:0]           caa = 16'h0000;
	rmc_pkg::rmc_key_type  kev;
	rmc_pkg::rmc_peer_type peer;
	rmc_pkg::rmc_line_type line, last;
	rmc_pkg::rmc_send_type send;
	logic [47:0]           conn_mac, bound_mac, friend_mac;
	logic [15:0]           net_id, short_addr;
	int                    n_errors = 0;
	int                    check_count = 0;
	int                    act_n = 0;
	int                    line_n = 0;
	int                    conn_n = 0;
	int                    send_n = 0;

	rmc_top #(.SCAN_UNIT_CYCLES(50)) u_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PEER_VALID(peer_v),
		.PEER(peer), .SCAN_ACTIVE(scan_act), .SCAN_LINE_VALID(line_v), .SCAN_LINE(line),
		.CONNECT_REQ(conn_req), .CONNECT_MAC(conn_mac), .BOUND_MAC(bound_mac),
		.LIGHT_SLEEP(light), .DEEP_SLEEP(deep), .ADVERTISE_EN(adv),
		.NET_SEND_VALID(send_v), .NET_SEND(send), .KEY_IN(key), .KEY_EVENT_VALID(kev_v),
		.KEY_EVENT(kev), .TX_DONE(tx_done), .CENTRAL_ASSIGN_VALID(cav),
		.CENTRAL_ASSIGN_ADDR(caa), .NET_ID(net_id), .SHORT_ADDR(short_addr),
		.RELAY_EN(relay), .FRIEND_MAC(friend_mac));
	rmc_radio_model u_radio (.CLK(clk), .SCAN_ACTIVE(scan_act),
		.KEY_EVENT_VALID(kev_v), .PEER_VALID(peer_v), .PEER(peer), .TX_DONE(tx_done));

	initial
		forever #10 clk = ~clk;

	// Count search cycles, result lines and pulses, keep the last line
	always @(posedge clk)
	begin
		if (scan_act === 1'b1)
			act_n++;
		if (line_v === 1'b1)
		begin
			line_n++;
			last = line;
		end
		if (conn_req === 1'b1)
			conn_n++;
		if (send_v === 1'b1)
			send_n++;
	end

	task complete_run;
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task chk(input logic [63:0] g, input logic [63:0] e);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	// One transfer, then an idle cycle so psel is never assigned twice at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			n_errors++;
			complete_run;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// Arguments first, then the command; reply code checked, result kept
	task cmd(input logic [7:0] op, input logic ha, input logic [31:0] a0,
		input logic [31:0] a1, input logic [1:0] er);
		apb(1'b1, 8'h04, a0);
		apb(1'b1, 8'h08, a1);
		apb(1'b1, 8'h00, {23'h0, ha, op});
		apb(1'b0, 8'h0C, 32'h0); // reply before next command
		chk(rd[1:0], er);
		apb(1'b0, 8'h10, 32'h0);
		res = rd;
	endtask : cmd

	task wait_idle;
		int i;
		for (i = 0; i < 500 && scan_act !== 1'b0; i++)
			@(posedge clk);
		if (i == 500)
		begin
			n_errors++;
			complete_run;
		end
	endtask : wait_idle

	// Key event comes three edges after the pin rises
	task wait_key;
		int i;
		for (i = 0; i < 8 && kev_v !== 1'b1; i++)
			@(posedge clk);
		if (i == 8)
		begin
			n_errors++;
			complete_run;
		end
	endtask : wait_key

	task done(input string s);
		$display("test %s done", s);
	endtask : done

	// Main sequence: defaults, mesh settings, master search, bus refusal
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({net_id, short_addr, adv, deep, relay}, 35'h5); // router default
		chk(friend_mac, 48'h0); // zero default
		done("reset");
		cmd(rmc_pkg::OP_SLEEP, 1, 1, 0, 2); // light refused in mesh
		cmd(rmc_pkg::OP_SLEEP, 1, 2, 0, 1); // deep accepted
		chk({deep, adv}, 2'b10); // deep stops advertising
		cmd(rmc_pkg::OP_NETID, 1, 32'hABCD, 0, 1); // set id
		chk(net_id, 16'hABCD); // id held
		cmd(rmc_pkg::OP_NETID, 0, 0, 0, 1); // query only
		chk({res, net_id}, 48'hABCD_ABCD); // unchanged
		cmd(rmc_pkg::OP_SADDR, 1, 0, 0, 2); // zero refused
		cmd(rmc_pkg::OP_SADDR, 1, 32'h1234, 0, 1); // set address
		chk(short_addr, 16'h1234); // address held
		cmd(rmc_pkg::OP_NET_SEND, 1, 32'h112233, 32'h1FFFF, 2); // bad lead
		cmd(rmc_pkg::OP_NET_SEND, 1, 32'h112233, 32'hFFFF, 1); // broadcast
		chk(send, {16'hFFFF, 1'b1, 32'h112233}); // frame fields
		chk(send_n, 1); // one frame sent
		cmd(rmc_pkg::OP_NODETYPE, 1, 1, 0, 1); // terminal
		chk({relay, deep}, 2'b01); // terminal idles asleep
		cmd(rmc_pkg::OP_KEYBIND, 1, 32'h13BEEF, 2, 1); // key 2 bound
		key <= 5'h02;
		wait_key; // key wakes node
		chk(kev, {16'hBEEF, 3'h3, 1'b1}); // event fields
		chk(deep, 0); // awake while sending
		repeat (2) @(posedge clk);
		chk(deep, 1); // asleep after send
		cmd(rmc_pkg::OP_NODETYPE, 1, 0, 0, 1); // router
		chk(relay, 1); // router relays
		cmd(rmc_pkg::OP_FRIEND_ADD, 1, 32'h33445566, 32'h1122, 1); // add
		chk(friend_mac, 48'h112233445566); // stored
		cmd(rmc_pkg::OP_FRIEND_CLR, 0, 0, 0, 1); // clear
		chk(friend_mac, 48'h0); // erased
		cmd(rmc_pkg::OP_DEFAULT, 0, 0, 0, 1); // restore
		chk({net_id, short_addr}, 32'h0); // defaults back
		cav <= 1'b1;
		caa <= 16'h0042;
		@(posedge clk);
		cav <= 1'b0;
		@(posedge clk);
		chk(short_addr, 16'h0042); // joiner addressed
		done("mesh");
		cmd(rmc_pkg::OP_MODE, 1, 1, 0, 1); // leave mesh
		chk(relay, 0); // no relay outside mesh
		cmd(rmc_pkg::OP_SLEEP, 1, 1, 0, 1); // light accepted
		chk({light, adv}, 2'b11); // light keeps advertising
		cmd(rmc_pkg::OP_SLEEP, 1, 2, 0, 2); // deep refused
		act_n = 0;
		line_n = 0;
		cmd(rmc_pkg::OP_SEARCH, 1, 0, 0, 1); // shortest search
		wait_idle; // ends by itself
		chk(act_n, 50); // one unit long
		chk({line_n[3:0], last}, {4'h3, 3'h2, 48'h6, 8'hB0}); // lines
		cmd(rmc_pkg::OP_SEARCH, 1, 4, 0, 1); // longest search, host aborts
		cmd(rmc_pkg::OP_SEARCH, 1, 0, 0, 2); // busy refusal
		cmd(rmc_pkg::OP_ABORT, 0, 0, 0, 1); // abort acknowledged
		chk(scan_act, 0); // stopped early
		cmd(rmc_pkg::OP_CONN_IDX, 1, 7, 0, 2); // past list end
		cmd(rmc_pkg::OP_CONN_IDX, 1, 1, 0, 1); // entry one
		chk(conn_mac, 48'h5); // strongest slot mac
		cmd(rmc_pkg::OP_CONN_IDX, 0, 0, 0, 1); // query
		chk(res, 32'h1); // index reported
		cmd(rmc_pkg::OP_CONN_ADDR, 1, 32'h33445566, 32'h1122, 1); // direct
		chk(conn_mac, 48'h112233445566); // address used
		cmd(rmc_pkg::OP_BIND, 1, 32'h778899AA, 32'hBBCC, 1); // bind
		chk(bound_mac, 48'hBBCC778899AA); // stored
		cmd(rmc_pkg::OP_BIND, 0, 0, 0, 1); // query
		chk(res, 32'h778899AA); // reported
		cmd(rmc_pkg::OP_UNBIND, 0, 0, 0, 1); // unbind
		chk(bound_mac, 48'h0); // cleared
		cmd(rmc_pkg::OP_AUTOBIND, 0, 0, 0, 1); // auto bind
		wait_idle; // search ends
		@(posedge clk);
		chk(bound_mac, 48'h5); // strongest bound
		chk(conn_mac, 48'h5); // strongest connected
		chk(conn_n, 3); // one request each from index, address and auto bind
		done("master");
		apb(1'b0, 8'h40, 32'h0);
		chk({err, rd}, {1'b1, 32'h0}); // unmapped read refused
		done("bus");
		complete_run;
	end
endmodule : tb_top
